//--- test/half_bridge_fault_supervisor_bench.sv
`timescale 1ns/1ps
module half_bridge_fault_supervisor_bench;
    import hbfs_pkg::*;
    localparam int OC = 4;
    localparam int UV = 6;
    localparam int UL = 8;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic en = 1'b1;
    logic vcc = 1'b1;
    logic dis = 1'b0;
    logic ov = 1'b0;
    logic uv = 1'b0;
    logic olsd = 1'b0;
    logic ovsd = 1'b0;
    logic go = 1'b0;
    logic clr = 1'b0;
    logic gsel = 1'b0;
    logic [7:0] warn = 8'h00;
    logic [7:0] shut = 8'h00;
    logic [7:0] oc_in = 8'h00;
    logic [7:0] ul = 8'h00;
    logic [7:0] req = 8'h00;
    logic [7:0] hs = 8'h00;
    logic [7:0] hb, hs_on, ls_on;
    logic dis_on, tsd_f, oc_f, ol_f, sf_f, tw_f, vuv_f, ign, rclr, cs_n, fcc, grp, done;
    int bad_count = 0;
    int checked = 0;
    int seed = 9;
    hbfs_supervisor #(.OC_CYCLES(OC), .UV_CYCLES(UV), .UL_CYCLES(UL)) u_hbfs_supervisor (
        .i_ref_clk(clk), .i_sys_rst(rst), .i_cs_n(cs_n), .i_en_pin(en), .i_vcc_ok(vcc),
        .i_vs_discharge(dis), .i_vs_overvolt(ov), .i_vs_undervolt(uv), .i_temp_warn(warn),
        .i_temp_shut(shut), .i_overcur(oc_in), .i_underload(ul), .i_fault_clear_command(fcc),
        .i_channel_group_select(grp), .i_open_load_shutoff_enable(olsd),
        .i_overvoltage_shutoff_enable(ovsd), .i_drive_req(req), .i_drive_hs(hs),
        .o_hb_active(hb), .o_hs_on(hs_on), .o_ls_on(ls_on), .o_discharge_on(dis_on),
        .o_thermal_shutdown_flag(tsd_f), .o_overcurrent_flag(oc_f), .o_open_load_flag(ol_f),
        .o_supply_fail_flag(sf_f), .o_heat_warning_flag(tw_f), .o_vcc_uv_flag(vuv_f),
        .o_serial_ignore(ign), .o_regs_clear(rclr));
    hbfs_host_model u_hbfs_host_model (.i_ref_clk(clk), .i_go(go), .i_clear(clr), .i_group(gsel),
        .o_cs_n(cs_n), .o_fault_clear_command(fcc), .o_channel_group_select(grp), .o_done(done));
    function automatic logic [7:0] hs_exp(input logic [7:0] r, input logic [7:0] h);
        return r & h;
    endfunction : hs_exp
    function automatic logic [7:0] ls_exp(input logic [7:0] r, input logic [7:0] h);
        return r & ~h;
    endfunction : ls_exp
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : end_sim
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        checked++;
        if (g !== e) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic wt(input int n);
        repeat (n) @(negedge clk);
    endtask : wt
    // One command frame through the host (clear bit c, group g), bounded wait for its end
    task automatic host(input logic c, input logic g);
        int k;
        clr = c;
        gsel = g;
        go = 1'b1;
        @(negedge clk);
        go = 1'b0;
        for (k = 0; k < 20 && done !== 1'b1; k++) @(negedge clk);
        if (done !== 1'b1) begin
            bad_count++;
            $display("CHECK FAILED host frame expected done seen timeout");
            end_sim();
        end
        wt(2);
    endtask : host
    initial begin
        forever #25 clk = ~clk;
    end
    initial begin
        wt(5);
        chk("ignore", 8'h01, 8'(ign));
        chk("regs_clear", 8'h01, 8'(rclr));
        rst = 1'b0;
        wt(4);
        repeat (4) begin
            req = 8'($random(seed));
            hs = 8'($random(seed));
            warn = 8'($random(seed));
            dis = 1'($random(seed));
            wt(4);
            chk("hb", req, hb);
            chk("hs_on", hs_exp(req, hs), hs_on);
            chk("ls_on", ls_exp(req, hs), ls_on);
            chk("warn", 8'(|warn), 8'(tw_f));
            chk("discharge", 8'(dis), 8'(dis_on));
        end
        warn = 8'h00;
        req = 8'hFF;
        hs = 8'hFF;
        ul = 8'hFF;
        wt(UL + 8);
        chk("ol brake", 8'h00, 8'(ol_f));
        hs = 8'hFE;
        wt(UL + 8);
        chk("ol", 8'h01, 8'(ol_f));
        chk("hb", 8'hFF, hb);
        ul = 8'h00;
        wt(4);
        chk("ol held", 8'h01, 8'(ol_f));
        host(1'b1, 1'b0);
        chk("ol clr", 8'h00, 8'(ol_f));
        olsd = 1'b1;
        ul = 8'h01;
        wt(UL + 8);
        chk("hb olsd", 8'hFE, hb);
        ul = 8'h00;
        host(1'b1, 1'b0);
        chk("hb olsd clr", 8'hFF, hb);
        olsd = 1'b0;
        hs = 8'hFF;
        oc_in = 8'h04;
        wt(2);
        oc_in = 8'h00;
        wt(OC + 6);
        chk("hb oc short", 8'hFF, hb);
        oc_in = 8'h04;
        wt(OC + 8);
        chk("hb oc", 8'hFB, hb);
        chk("oc", 8'h01, 8'(oc_f));
        host(1'b1, 1'b0);
        wt(OC + 4);
        chk("oc again", 8'h01, 8'(oc_f));
        oc_in = 8'h00;
        host(1'b1, 1'b1);
        chk("hb other grp", 8'hFB, hb);
        chk("oc other grp", 8'h00, 8'(oc_f));
        host(1'b1, 1'b0);
        chk("hb oc clr", 8'hFF, hb);
        chk("oc clr", 8'h00, 8'(oc_f));
        shut = 8'h80;
        wt(4);
        host(1'b1, 1'b1);
        chk("tsd hot", 8'h01, 8'(tsd_f));
        chk("hb tsd", 8'h7F, hb);
        chk("hs_on tsd", 8'h7F, hs_on);
        chk("warn tsd", 8'h01, 8'(tw_f));
        shut = 8'h00;
        wt(4);
        chk("tsd cool", 8'h01, 8'(tsd_f));
        host(1'b0, 1'b1);
        chk("tsd no clr", 8'h01, 8'(tsd_f));
        host(1'b1, 1'b1);
        chk("tsd clr", 8'h00, 8'(tsd_f));
        chk("hb tsd clr", 8'hFF, hb);
        ov = 1'b1;
        wt(4);
        chk("sf ov", 8'h01, 8'(sf_f));
        chk("hb ov", 8'hFF, hb);
        ovsd = 1'b1;
        wt(4);
        chk("hb ovsd", 8'h00, hb);
        ov = 1'b0;
        wt(4);
        chk("hb ov end", 8'hFF, hb);
        chk("sf ov end", 8'h00, 8'(sf_f));
        ovsd = 1'b0;
        uv = 1'b1;
        wt(UV + 8);
        chk("hb uv", 8'h00, hb);
        chk("sf uv", 8'h01, 8'(sf_f));
        uv = 1'b0;
        wt(4);
        chk("hb uv end", 8'hFF, hb);
        chk("sf uv end", 8'h00, 8'(sf_f));
        vcc = 1'b0;
        wt(4);
        chk("hb vcc", 8'h00, hb);
        chk("ignore vcc", 8'h01, 8'(ign));
        chk("vcc uv", 8'h01, 8'(vuv_f));
        vcc = 1'b1;
        wt(4);
        chk("vcc uv end", 8'h00, 8'(vuv_f));
        chk("ignore end", 8'h00, 8'(ign));
        en = 1'b0;
        wt(4);
        chk("regs_clear en", 8'h01, 8'(rclr));
        chk("hb en", 8'h00, hb);
        en = 1'b1;
        wt(4);
        chk("hb en back", 8'hFF, hb);
        end_sim();
    end
endmodule : half_bridge_fault_supervisor_bench

//--- test/hbfs_host_model.sv
`timescale 1ns/1ps
module hbfs_host_model (
    input wire logic i_ref_clk,
    input wire logic i_go,
    input wire logic i_clear,
    input wire logic i_group,
    output logic o_cs_n,
    output logic o_fault_clear_command,
    output logic o_channel_group_select,
    output logic o_done
);
    int cnt = 0;
    logic clr_q = 1'b0;
    logic grp_q = 1'b0;
    initial begin
        o_cs_n = 1'b1;
        o_fault_clear_command = 1'b0;
        o_channel_group_select = 1'b0;
        o_done = 1'b0;
    end
    // Frame sequencer
    always @(posedge i_ref_clk) begin
        if (cnt == 0 && i_go) begin
            cnt <= 1;
            clr_q <= i_clear;
            grp_q <= i_group;
        end else if (cnt != 0) begin
            cnt <= (cnt == 12) ? 0 : cnt + 1;
        end
    end
    // Command bits set while selected, held past the select rise
    always @(negedge i_ref_clk) begin
        o_cs_n <= !(cnt >= 1 && cnt <= 5);
        if (cnt == 1) begin
            o_fault_clear_command <= clr_q;
            o_channel_group_select <= grp_q;
        end
        o_done <= (cnt == 12);
    end
endmodule : hbfs_host_model

//--- verilog/hbfs_delay_timer.sv
`timescale 1ns/1ps
module hbfs_delay_timer #(
    parameter int CYCLES = 200
) (
    input wire logic i_ref_clk,
    input wire logic i_sys_rst,
    input wire logic i_run,
    output logic o_expired
);
    import hbfs_pkg::*;
    localparam int W = $clog2(CYCLES + 1);
    localparam logic [W-1:0] LAST = W'(CYCLES);

    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;

    // Restarts whenever the condition goes away before expiry
    always_comb begin
        if (!i_run) begin
            cnt_d = '0;
        end else if (cnt_q != LAST) begin
            cnt_d = cnt_q + W'(1);
        end else begin
            cnt_d = cnt_q;
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    assign o_expired = i_run && (cnt_q == LAST);

    a_timer_restart: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        !i_run |=> cnt_q == '0)
        else $error("delay timer did not restart");
endmodule : hbfs_delay_timer

//--- verilog/hbfs_pkg.sv
package hbfs_pkg;
    // Channels and channel groups
    localparam int NUM_CH = 8;
    localparam logic [7:0] GRP_LOW_MASK = 8'h3F;
    localparam logic [7:0] GRP_HIGH_MASK = 8'hC0;
    // Delay counts at 20 MHz (values are not fixed by the device)
    localparam int CLK_HZ = 20_000_000;
    localparam int OC_DELAY_NS = 10_000;
    localparam int UV_DELAY_NS = 100_000;
    localparam int UL_DELAY_NS = 200_000;
    localparam int OC_DELAY_CYC = (OC_DELAY_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int UV_DELAY_CYC = (UV_DELAY_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int UL_DELAY_CYC = (UL_DELAY_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    // Synchroniser vector layout
    localparam int SYNC_W = 38;
    localparam int S_CS = 37;
    localparam int S_EN = 36;
    localparam int S_VCC = 35;
    localparam int S_DIS = 34;
    localparam int S_OV = 33;
    localparam int S_UV = 32;
    localparam int S_WARN = 24;
    localparam int S_SHUT = 16;
    localparam int S_OC = 8;
    localparam int S_UL = 0;
    localparam logic [SYNC_W-1:0] SYNC_RST = 38'h20_0000_0000;
    typedef enum logic {HBFS_SLEEP, HBFS_RUN} hbfs_mode_t;
endpackage : hbfs_pkg

//--- verilog/hbfs_supervisor.sv
`timescale 1ns/1ps
module hbfs_supervisor #(
    parameter int OC_CYCLES = hbfs_pkg::OC_DELAY_CYC,
    parameter int UV_CYCLES = hbfs_pkg::UV_DELAY_CYC,
    parameter int UL_CYCLES = hbfs_pkg::UL_DELAY_CYC
) (
    input wire logic i_ref_clk,
    input wire logic i_sys_rst,
    input wire logic i_cs_n,
    input wire logic i_en_pin,
    input wire logic i_vcc_ok,
    input wire logic i_vs_discharge,
    input wire logic i_vs_overvolt,
    input wire logic i_vs_undervolt,
    input wire logic [hbfs_pkg::NUM_CH-1:0] i_temp_warn,
    input wire logic [hbfs_pkg::NUM_CH-1:0] i_temp_shut,
    input wire logic [hbfs_pkg::NUM_CH-1:0] i_overcur,
    input wire logic [hbfs_pkg::NUM_CH-1:0] i_underload,
    input wire logic i_fault_clear_command,
    input wire logic i_channel_group_select,
    input wire logic i_open_load_shutoff_enable,
    input wire logic i_overvoltage_shutoff_enable,
    input wire logic [hbfs_pkg::NUM_CH-1:0] i_drive_req,
    input wire logic [hbfs_pkg::NUM_CH-1:0] i_drive_hs,
    output logic [hbfs_pkg::NUM_CH-1:0] o_hb_active,
    output logic [hbfs_pkg::NUM_CH-1:0] o_hs_on,
    output logic [hbfs_pkg::NUM_CH-1:0] o_ls_on,
    output logic o_discharge_on,
    output logic o_thermal_shutdown_flag,
    output logic o_overcurrent_flag,
    output logic o_open_load_flag,
    output logic o_supply_fail_flag,
    output logic o_heat_warning_flag,
    output logic o_vcc_uv_flag,
    output logic o_serial_ignore,
    output logic o_regs_clear
);
    import hbfs_pkg::*;

    function automatic logic [NUM_CH-1:0] grp_mask(input logic sel);
        grp_mask = sel ? GRP_HIGH_MASK : GRP_LOW_MASK;
    endfunction : grp_mask

    // Two-stage synchroniser for the chip-select, enable, supply, discharge and per-channel sensor inputs
    logic [SYNC_W-1:0] s1_q;
    logic [SYNC_W-1:0] s1_d;
    logic [SYNC_W-1:0] s2_q;
    logic [SYNC_W-1:0] s2_d;
    logic cs_prev_q;
    logic cs_prev_d;
    always_comb begin
        s1_d = {i_cs_n, i_en_pin, i_vcc_ok, i_vs_discharge, i_vs_overvolt, i_vs_undervolt,
                i_temp_warn, i_temp_shut, i_overcur, i_underload};
        s2_d = s1_q;
        cs_prev_d = s2_q[S_CS];
    end

    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            s1_q <= SYNC_RST;
            s2_q <= SYNC_RST;
            cs_prev_q <= 1'b1;
        end else begin
            s1_q <= s1_d;
            s2_q <= s2_d;
            cs_prev_q <= cs_prev_d;
        end
    end

    logic en_s;
    logic vcc_s;
    logic [NUM_CH-1:0] warn_s;
    logic [NUM_CH-1:0] shut_s;
    logic [NUM_CH-1:0] oc_s;
    logic [NUM_CH-1:0] ul_s;
    assign en_s = s2_q[S_EN];
    assign vcc_s = s2_q[S_VCC];
    assign warn_s = s2_q[S_WARN +: NUM_CH];
    assign shut_s = s2_q[S_SHUT +: NUM_CH];
    assign oc_s = s2_q[S_OC +: NUM_CH];
    assign ul_s = s2_q[S_UL +: NUM_CH];

    // Delay timers
    logic [NUM_CH-1:0] oc_exp;
    logic uv_exp;
    logic ul_exp;
    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++) begin : g_oc
            hbfs_delay_timer #(.CYCLES(OC_CYCLES)) u_oc_timer (
                .i_ref_clk(i_ref_clk),
                .i_sys_rst(i_sys_rst),
                .i_run(oc_s[g]),
                .o_expired(oc_exp[g])
            );
        end
    endgenerate

    hbfs_delay_timer #(.CYCLES(UV_CYCLES)) u_uv_timer (
        .i_ref_clk(i_ref_clk),
        .i_sys_rst(i_sys_rst),
        .i_run(s2_q[S_UV]),
        .o_expired(uv_exp)
    );

    logic [NUM_CH-1:0] ul_live;
    assign ul_live = ul_s & o_ls_on;
    // One shared timer: later channels see only the remaining delay
    hbfs_delay_timer #(.CYCLES(UL_CYCLES)) u_ul_timer (
        .i_ref_clk(i_ref_clk),
        .i_sys_rst(i_sys_rst),
        .i_run(|ul_live),
        .o_expired(ul_exp)
    );

    // Supervisor state
    hbfs_mode_t mode_q;
    hbfs_mode_t mode_d;
    logic [NUM_CH-1:0] tsd_q;
    logic [NUM_CH-1:0] tsd_d;
    logic [NUM_CH-1:0] ocl_q;
    logic [NUM_CH-1:0] ocl_d;
    logic [NUM_CH-1:0] ol_q;
    logic [NUM_CH-1:0] ol_d;
    logic [NUM_CH-1:0] olo_q;
    logic [NUM_CH-1:0] olo_d;
    logic [NUM_CH-1:0] act_d;
    logic [NUM_CH-1:0] hs_d;
    logic [NUM_CH-1:0] ls_d;
    logic dis_d;
    logic sfail_d;
    logic tw_d;
    logic tsf_d;
    logic ocf_d;
    logic olf_d;
    logic vuv_d;
    logic ign_d;
    logic rclr_d;

    logic run;
    logic cs_rise;
    logic clr;
    logic global_off;
    logic [NUM_CH-1:0] clr_mask;
    logic [NUM_CH-1:0] ol_set;
    logic [NUM_CH-1:0] sel_mask;

    always_comb begin
        run = en_s && vcc_s;
        mode_d = run ? HBFS_RUN : HBFS_SLEEP;
        cs_rise = s2_q[S_CS] && !cs_prev_q;
        // Clear executes only at chip-select rising edge, and only when serial is alive
        clr = (mode_q == HBFS_RUN) && cs_rise && i_fault_clear_command;
        clr_mask = clr ? grp_mask(i_channel_group_select) : '0;
        sel_mask = grp_mask(i_channel_group_select);
        ol_set = ul_live & {NUM_CH{ul_exp}};
        if (!run) begin
            tsd_d = '0;
            ocl_d = '0;
            ol_d = '0;
            olo_d = '0;
        end else begin
            tsd_d = (tsd_q & ~(clr_mask & ~shut_s)) | shut_s;
            ocl_d = (ocl_q & ~clr_mask) | oc_exp;
            ol_d = (ol_q & ~clr_mask) | ol_set;
            olo_d = (olo_q & ~clr_mask)
                  | (ol_set & {NUM_CH{i_open_load_shutoff_enable}}
                     & grp_mask(i_channel_group_select));
        end
        global_off = !run || uv_exp || (s2_q[S_OV] && i_overvoltage_shutoff_enable);
        // Unlatched lockouts fall back to the requested drive
        act_d = i_drive_req & ~tsd_d & ~ocl_d & ~olo_d & ~{NUM_CH{global_off}};
        hs_d = act_d & i_drive_hs;
        ls_d = act_d & ~i_drive_hs;
        dis_d = s2_q[S_DIS];
        sfail_d = run && (s2_q[S_OV] || uv_exp);
        tw_d = run && |(warn_s | shut_s | tsd_d);
        tsf_d = |(tsd_d & grp_mask(i_channel_group_select));
        ocf_d = |(ocl_d & grp_mask(i_channel_group_select));
        olf_d = |(ol_d & grp_mask(i_channel_group_select));
        vuv_d = !vcc_s;
        ign_d = !vcc_s;
        rclr_d = !run;
    end

    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            mode_q <= HBFS_SLEEP;
            tsd_q <= '0;
            ocl_q <= '0;
            ol_q <= '0;
            olo_q <= '0;
            o_hb_active <= '0;
            o_hs_on <= '0;
            o_ls_on <= '0;
            o_discharge_on <= 1'b0;
            o_supply_fail_flag <= 1'b0;
            o_heat_warning_flag <= 1'b0;
            o_thermal_shutdown_flag <= 1'b0;
            o_overcurrent_flag <= 1'b0;
            o_open_load_flag <= 1'b0;
            o_vcc_uv_flag <= 1'b0;
            o_serial_ignore <= 1'b1;
            o_regs_clear <= 1'b1;
        end else begin
            mode_q <= mode_d;
            tsd_q <= tsd_d;
            ocl_q <= ocl_d;
            ol_q <= ol_d;
            olo_q <= olo_d;
            o_hb_active <= act_d;
            o_hs_on <= hs_d;
            o_ls_on <= ls_d;
            o_discharge_on <= dis_d;
            o_supply_fail_flag <= sfail_d;
            o_heat_warning_flag <= tw_d;
            o_thermal_shutdown_flag <= tsf_d;
            o_overcurrent_flag <= ocf_d;
            o_open_load_flag <= olf_d;
            o_vcc_uv_flag <= vuv_d;
            o_serial_ignore <= ign_d;
            o_regs_clear <= rclr_d;
        end
    end

    // Checks
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (i_sys_rst);

    sequence s_clear_now;
        run && clr;
    endsequence

    sequence s_cs_end;
        !s2_q[S_CS] ##1 s2_q[S_CS];
    endsequence

    sequence s_no_latch;
        run && (tsd_d == '0) && (ocl_d == '0) && (olo_d == '0);
    endsequence

    sequence s_uv_expired;
        run && uv_exp;
    endsequence

    sequence s_all_off;
        (o_hb_active == '0) && o_supply_fail_flag;
    endsequence

    a_discharge_follow: assert property (s2_q[S_DIS] |=> o_discharge_on)
        else $error("discharge path not active above threshold");
    a_tsd_latch_off: assert property (run && (shut_s != '0) |=>
        ((tsd_q & $past(shut_s)) == $past(shut_s)) && ((o_hb_active & $past(shut_s)) == '0))
        else $error("hot channel not latched off");
    a_tsd_hold: assert property (run && !clr && (tsd_q != '0) |=>
        !run || ((tsd_q & $past(tsd_q)) == $past(tsd_q)))
        else $error("shutdown latch dropped without clear");
    a_clear_group: assert property (s_clear_now ##0 (oc_exp == '0) |=>
        !run || (((ocl_q ^ $past(ocl_q)) & ~$past(clr_mask)) == '0))
        else $error("clear touched the other group");
    a_oc_release: assert property (s_clear_now ##0 ((oc_exp & clr_mask) == '0) |=>
        (ocl_q & $past(clr_mask)) == '0)
        else $error("over-current latch not cleared");
    a_oc_hiz: assert property (run && (oc_exp != '0) |=>
        (o_hb_active & $past(oc_exp)) == '0)
        else $error("shorted output still active");
    a_ov_flag: assert property (run && s2_q[S_OV] |=> o_supply_fail_flag)
        else $error("supply fail not set on over-voltage");
    a_ov_shutoff: assert property (run && s2_q[S_OV] && i_overvoltage_shutoff_enable |=>
        o_hb_active == '0)
        else $error("outputs on during over-voltage shutoff");
    a_supply_recover: assert property (run && !s2_q[S_OV] && !s2_q[S_UV] |=>
        !o_supply_fail_flag)
        else $error("supply fail stuck after recovery");
    a_warn_clear: assert property (run && (warn_s == '0) && (shut_s == '0) && (tsd_q == '0)
        && (clr_mask == '0) |=> !o_heat_warning_flag)
        else $error("heat warning stuck");
    a_sleep_off: assert property (!run |=> (o_hb_active == '0) && o_regs_clear
        && (tsd_q == '0))
        else $error("sleep did not shut outputs");
    a_cs_only: assert property ($changed(ocl_q) && ((ocl_q & ~$past(ocl_q)) == '0)
        && run && $past(run) |-> $past(cs_rise))
        else $error("latch cleared outside chip-select edge");
    a_discharge_off: assert property (!s2_q[S_DIS] |=> !o_discharge_on)
        else $error("discharge path on below threshold");
    a_ol_flag_set: assert property (run && (ol_set != '0) |=>
        (ol_q & $past(ol_set)) == $past(ol_set))
        else $error("open-load latch not set");
    a_ol_no_shutoff: assert property (run && !i_open_load_shutoff_enable && (olo_q == '0) |=>
        olo_q == '0)
        else $error("open load shut a channel while shutoff disabled");
    a_olo_latch: assert property (run && i_open_load_shutoff_enable && ((ol_set & sel_mask) != '0) |=>
        ((olo_q & $past(ol_set & sel_mask)) == $past(ol_set & sel_mask))
        && ((o_hb_active & $past(ol_set & sel_mask)) == '0))
        else $error("open-load channel not latched off");
    a_lockout_restore: assert property (s_no_latch ##0 !s2_q[S_UV]
        ##0 !(s2_q[S_OV] && i_overvoltage_shutoff_enable) |=> o_hb_active == $past(i_drive_req))
        else $error("output not restored after lockout");
    a_uv_lockout: assert property (s_uv_expired |=> s_all_off)
        else $error("outputs on after supply lockout delay");
    a_clear_at_edge: assert property (s_cs_end ##0 ((mode_q == HBFS_RUN) && i_fault_clear_command)
        |-> clr)
        else $error("clear not executed at chip-select rise");
    a_clear_needs_rise: assert property (clr |-> s2_q[S_CS] && !$past(s2_q[S_CS]))
        else $error("clear executed away from chip-select rise");
    a_vcc_low_off: assert property (!vcc_s |=> o_serial_ignore && o_vcc_uv_flag
        && (o_hb_active == '0) && (o_hs_on == '0) && (o_ls_on == '0))
        else $error("logic supply low but serial or outputs alive");
    a_vcc_recover: assert property (vcc_s |=> !o_vcc_uv_flag && !o_serial_ignore)
        else $error("logic supply indication stuck");
    a_warn_set: assert property (run && ((warn_s | shut_s) != '0) |=> o_heat_warning_flag)
        else $error("heat warning missing");
    a_ol_low_side: assert property (run |=> (ol_q & ~$past(ol_q) & ~$past(o_ls_on)) == '0)
        else $error("open load set on a channel with low side off");
    a_oc_retrigger: assert property (s_clear_now ##0 (oc_exp != '0) |=>
        (ocl_q & $past(oc_exp)) == $past(oc_exp))
        else $error("persisting over-current not latched again");
    a_tsd_hot_keep: assert property (s_clear_now ##0 ((shut_s & clr_mask) != '0) |=>
        (tsd_q & $past(shut_s & clr_mask)) == $past(shut_s & clr_mask))
        else $error("hot channel released by clear");
    a_tsd_release: assert property (s_clear_now |=> (tsd_q & $past(clr_mask & ~shut_s)) == '0)
        else $error("cool channel not released by clear");
endmodule : hbfs_supervisor
